// *** adcsc_regs.svh ***
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef ADCSC_REGS_SVH
`define ADCSC_REGS_SVH
`define ADCSC_OFF_MAIN      12'h000
`define ADCSC_OFF_CHAN      12'h004
`define ADCSC_OFF_TIMING    12'h008
`define ADCSC_OFF_DMALEN    12'h00c
`define ADCSC_OFF_RESULT    12'h010
`define ADCSC_OFF_DMAADDR   12'h014
`define ADCSC_OFF_SCAN      12'h018
`define ADCSC_OFF_IRQ_STAT  12'h01c
`define ADCSC_OFF_IRQ_MASK  12'h020
`define ADCSC_B_MODULE_ON   15
`define ADCSC_B_IDLE_STOP   13
`define ADCSC_B_DMA_BUILD   12
`define ADCSC_B_RES_SEL     10
`define ADCSC_B_SIMSAMPLE   3
`define ADCSC_B_AUTOSAMPLE  2
`define ADCSC_B_SAMPLE      1
`define ADCSC_B_DONE        0
`define ADCSC_B_SCAN_EN     10
`define ADCSC_B_HALF_STAT   7
`define ADCSC_B_SPLIT_MODE  1
`define ADCSC_RST_16        16'h0000
`define ADCSC_CONV_TAD_10   6'd12
`define ADCSC_CONV_TAD_12   6'd14
`endif

// *** adcsc_pkg.sv ***
// types shared by the converter sequencer files
package adcsc_pkg;
    typedef enum logic [1:0] {
        ADCSC_ST_OFF,
        ADCSC_ST_SAMPLE,
        ADCSC_ST_CONVERT,
        ADCSC_ST_HOLD
    } adcsc_state_e;
    typedef logic [15:0] adcsc_word_t;
endpackage

// *** adcsc_format.sv ***
// result formatter: places a raw conversion result into the output word
`timescale 1ns/100ps
`include "adcsc_regs.svh"
module adcsc_format
    import adcsc_pkg::*;
(
    input  wire logic [11:0] raw_i,
    input  wire logic        res12_i,
    input  wire logic [1:0]  format_i,
    output adcsc_word_t      word_o
);
    wire logic [9:0]  d10 = raw_i[9:0];
    wire logic        s10 = ~raw_i[9];
    wire logic        s12 = ~raw_i[11];
    adcsc_word_t w10;
    adcsc_word_t w12;
    always_comb begin
        case (format_i)
            2'h3:    w10 = {s10, d10[8:0], 6'h00};
            2'h2:    w10 = {d10, 6'h00};
            2'h1:    w10 = {{7{s10}}, d10[8:0]};
            default: w10 = {6'h00, d10};
        endcase
        case (format_i)
            2'h3:    w12 = {s12, raw_i[10:0], 4'h0};
            2'h2:    w12 = {raw_i, 4'h0};
            2'h1:    w12 = {{5{s12}}, raw_i[10:0]};
            default: w12 = {4'h0, raw_i};
        endcase
    end
    assign word_o = res12_i ? w12 : w10;
endmodule

// *** adcsc_core.sv ***
// converter sequencer top: apb registers, sample/convert sequencing, dma addressing, interrupt
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "adcsc_regs.svh"
module adcsc_core
    import adcsc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        device_idle_i,
    input  wire logic        trig_pwm_i,
    input  wire logic        trig_timer_i,
    input  wire logic        trig_pin_i,
    output logic             sample_o,
    output logic      [3:0]  sample_chan_o,
    output logic      [4:0]  ch0_input_o,
    input  wire logic [11:0] conv_data_i,
    output logic             dma_req_o,
    output logic      [10:0] dma_addr_o,
    output logic             irq_o
);
    logic [15:0] main_reg;
    logic [15:0] chan_reg;
    logic [15:0] timing_reg;
    logic [2:0]  dmalen_reg;
    logic [31:0] scan_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    adcsc_word_t result_reg;
    logic [10:0] dma_addr_reg;
    logic        dma_req_reg;
    adcsc_state_e state_reg;
    adcsc_state_e state_next;
    logic [5:0]  div_reg;
    logic [5:0]  tad_cnt_reg;
    logic [1:0]  chan_idx_reg;
    logic [3:0]  smp_cnt_reg;
    logic        half_reg;
    logic [4:0]  scan_pos_reg;
    logic [6:0]  conv_seq_reg;
    logic        trig_pwm_d;
    logic        trig_timer_d;
    logic        trig_pin_d;

    // apb decode: one wait-free access phase, unmapped addresses answer with an error
    wire logic wr_en = psel_i & penable_i & pwrite_i;
    wire logic rd_en = psel_i & penable_i & ~pwrite_i;
    // read data is captured in the setup cycle so it already stands at the access edge
    wire logic rd_setup = psel_i & ~penable_i & ~pwrite_i;
    wire logic hit_main = paddr_i == `ADCSC_OFF_MAIN;
    wire logic hit_chan = paddr_i == `ADCSC_OFF_CHAN;
    wire logic hit_timing = paddr_i == `ADCSC_OFF_TIMING;
    wire logic hit_dmalen = paddr_i == `ADCSC_OFF_DMALEN;
    wire logic hit_result = paddr_i == `ADCSC_OFF_RESULT;
    wire logic hit_dmaaddr = paddr_i == `ADCSC_OFF_DMAADDR;
    wire logic hit_scan = paddr_i == `ADCSC_OFF_SCAN;
    wire logic hit_stat = paddr_i == `ADCSC_OFF_IRQ_STAT;
    wire logic hit_mask = paddr_i == `ADCSC_OFF_IRQ_MASK;
    wire logic hit_any = hit_main | hit_chan | hit_timing | hit_dmalen | hit_result
                         | hit_dmaaddr | hit_scan | hit_stat | hit_mask;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit_any;

    wire logic module_on = main_reg[`ADCSC_B_MODULE_ON];
    wire logic res12 = main_reg[`ADCSC_B_RES_SEL];
    wire logic [1:0] output_format = main_reg[9:8];
    wire logic [2:0] conversion_trigger_source = main_reg[7:5];
    wire logic auto_sample = main_reg[`ADCSC_B_AUTOSAMPLE];
    wire logic sample_bit = main_reg[`ADCSC_B_SAMPLE];
    wire logic simultaneous_sample = main_reg[`ADCSC_B_SIMSAMPLE] & ~res12;
    wire logic [1:0] channel_count = res12 ? 2'h0 : chan_reg[9:8];
    wire logic [3:0] samples_per_event = chan_reg[5:2];
    wire logic split_mode = chan_reg[`ADCSC_B_SPLIT_MODE];
    wire logic scan_enable = chan_reg[`ADCSC_B_SCAN_EN];
    wire logic [4:0] auto_sample_time = timing_reg[12:8];
    wire logic [5:0] conversion_clock_divisor = timing_reg[5:0];

    // idle_stop freezes the sequencer; module_on off forces the state to off and stops sampling and dma requests
    wire logic halted = main_reg[`ADCSC_B_IDLE_STOP] & device_idle_i;
    wire logic run = module_on & ~halted;

    // one conversion clock period is divisor+1 system clocks
    wire logic tad_tick = run && (div_reg == conversion_clock_divisor);

    wire logic pwm_edge = trig_pwm_i & ~trig_pwm_d;
    wire logic timer_edge = trig_timer_i & ~trig_timer_d;
    wire logic pin_edge = trig_pin_i & ~trig_pin_d;
    // the trigger fires on the tick that completes the programmed number of periods
    wire logic samc_reached = 6'(tad_cnt_reg + 6'h01) >= {1'b0, auto_sample_time};
    logic hw_trigger;
    always_comb begin
        case (conversion_trigger_source)
            3'h7:    hw_trigger = tad_tick && samc_reached;
            3'h3:    hw_trigger = pwm_edge;
            3'h2:    hw_trigger = timer_edge;
            3'h1:    hw_trigger = pin_edge;
            default: hw_trigger = 1'b0;
        endcase
    end
    wire logic sw_main_wr = wr_en & hit_main;
    wire logic sw_end_sample = sw_main_wr & ~pwdata_i[`ADCSC_B_SAMPLE]
                               & (conversion_trigger_source == 3'h0);
    wire logic start_conv = run && (state_reg == ADCSC_ST_SAMPLE)
                            && (hw_trigger || sw_end_sample);
    wire logic [5:0] conv_len = res12 ? `ADCSC_CONV_TAD_12 : `ADCSC_CONV_TAD_10;
    wire logic [5:0] conv_last = 6'(conv_len - 6'h01);
    wire logic [1:0] last_chan = channel_count[1] ? 2'h3 : {1'b0, channel_count[0]};
    // simultaneous sampling converts all held channels back to back after one sample phase
    wire logic conv_end = tad_tick && (state_reg == ADCSC_ST_CONVERT)
                          && (tad_cnt_reg == conv_last);
    wire logic seq_more = conv_end && (chan_idx_reg != last_chan);
    wire logic seq_done = conv_end && (chan_idx_reg == last_chan);
    wire logic event_done = seq_done && (smp_cnt_reg == samples_per_event);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ADCSC_ST_OFF:     state_next = ADCSC_ST_HOLD;
            ADCSC_ST_HOLD:    if (auto_sample || (sw_main_wr && pwdata_i[`ADCSC_B_SAMPLE])) begin
                state_next = ADCSC_ST_SAMPLE;
            end
            ADCSC_ST_SAMPLE:  if (start_conv) begin
                state_next = ADCSC_ST_CONVERT;
            end
            ADCSC_ST_CONVERT: if (seq_more && !simultaneous_sample) begin
                state_next = ADCSC_ST_SAMPLE;
            end else if (seq_done) begin
                state_next = auto_sample ? ADCSC_ST_SAMPLE : ADCSC_ST_HOLD;
            end
            default:          state_next = ADCSC_ST_OFF;
        endcase
        if (!module_on) begin
            state_next = ADCSC_ST_OFF;
        end else if (halted) begin
            state_next = state_reg;
        end
    end

    // scan walks the selected inputs in ascending order, wrapping round
    logic [4:0] scan_nxt;
    always_comb begin
        scan_nxt = scan_pos_reg;
        for (int k = 31; k >= 1; k--) begin
            if (scan_reg[5'(scan_pos_reg + 5'(k))]) begin
                scan_nxt = 5'(scan_pos_reg + 5'(k));
            end
        end
    end

    // dma word size per input is 2^buffer_length; scatter address = input index * size + slot
    wire logic [7:0] buf_words = 8'h01 << dmalen_reg;
    wire logic [4:0] cur_input = (chan_idx_reg == 2'h0)
                                 ? (scan_enable ? scan_pos_reg : ch0_input_o)
                                 : {3'h0, chan_idx_reg};
    wire logic [6:0] slot = conv_seq_reg & 7'(buf_words - 8'h01);
    wire logic [10:0] scatter_addr = 11'({cur_input, 7'h00} >> (3'h7 - dmalen_reg)) | {4'h0, slot};
    wire logic [10:0] order_addr = {2'h0, half_reg & split_mode, 4'h0, smp_cnt_reg} ;
    wire logic [10:0] addr_sel = main_reg[`ADCSC_B_DMA_BUILD] ? order_addr : scatter_addr;
    wire adcsc_word_t fmt_word;

    adcsc_format u_format (
        .raw_i    (conv_data_i),
        .res12_i  (res12),
        .format_i (output_format),
        .word_o   (fmt_word)
    );

    // a status read clears only the bits it reported; an event in any cycle still lands
    wire logic stat_rd = rd_en & hit_stat;
    wire logic [1:0] irq_events = {seq_done, event_done};

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            main_reg     <= `ADCSC_RST_16;
            chan_reg     <= `ADCSC_RST_16;
            timing_reg   <= `ADCSC_RST_16;
            dmalen_reg   <= 3'h0;
            scan_reg     <= 32'h0000_0000;
            irq_mask_reg <= 2'h0;
            irq_stat_reg <= 2'h0;
        end else begin
            if (sw_main_wr) begin
                main_reg[15:2] <= pwdata_i[15:2];
                if (state_reg == ADCSC_ST_OFF || !pwdata_i[`ADCSC_B_MODULE_ON]) begin
                    main_reg[`ADCSC_B_RES_SEL] <= pwdata_i[`ADCSC_B_RES_SEL];
                end else begin
                    main_reg[`ADCSC_B_RES_SEL] <= main_reg[`ADCSC_B_RES_SEL];
                end
            end
            main_reg[`ADCSC_B_SAMPLE] <= (state_next == ADCSC_ST_SAMPLE);
            if (conv_end) begin
                main_reg[`ADCSC_B_DONE] <= 1'b1;
            end else if (start_conv || (sw_main_wr && !pwdata_i[`ADCSC_B_DONE])) begin
                main_reg[`ADCSC_B_DONE] <= 1'b0;
            end
            if (wr_en && hit_chan) begin
                chan_reg <= {pwdata_i[15:8], 1'b0, 1'b0, pwdata_i[5:0]};
            end
            chan_reg[`ADCSC_B_HALF_STAT] <= half_reg;
            if (wr_en && hit_timing) begin
                timing_reg <= {3'h0, pwdata_i[12:8], 2'h0, pwdata_i[5:0]};
            end
            if (wr_en && hit_dmalen) begin
                dmalen_reg <= pwdata_i[2:0];
            end
            if (wr_en && hit_scan) begin
                scan_reg <= pwdata_i;
            end
            if (wr_en && hit_mask) begin
                irq_mask_reg <= pwdata_i[1:0];
            end
            irq_stat_reg <= (irq_stat_reg & ~(stat_rd ? prdata_o[1:0] : 2'h0)) | irq_events;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg    <= ADCSC_ST_OFF;
            div_reg      <= 6'h00;
            tad_cnt_reg  <= 6'h00;
            chan_idx_reg <= 2'h0;
            smp_cnt_reg  <= 4'h0;
            half_reg     <= 1'b0;
            scan_pos_reg <= 5'h00;
            conv_seq_reg <= 7'h00;
            trig_pwm_d   <= 1'b0;
            trig_timer_d <= 1'b0;
            trig_pin_d   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            trig_pwm_d   <= trig_pwm_i;
            trig_timer_d <= trig_timer_i;
            trig_pin_d   <= trig_pin_i;
            // realign the conversion clock at each phase change so phase lengths are exact
            div_reg      <= (!run || tad_tick || state_next != state_reg)
                            ? 6'h00 : 6'(div_reg + 6'h01);
            if (state_next != state_reg || conv_end) begin
                tad_cnt_reg <= 6'h00;
            end else if (tad_tick && tad_cnt_reg != 6'h3f) begin
                tad_cnt_reg <= 6'(tad_cnt_reg + 6'h01);
            end
            if (!module_on) begin
                chan_idx_reg <= 2'h0;
                smp_cnt_reg  <= 4'h0;
                half_reg     <= 1'b0;
                conv_seq_reg <= 7'h00;
            end else if (seq_more) begin
                chan_idx_reg <= 2'(chan_idx_reg + 2'h1);
            end else if (seq_done) begin
                chan_idx_reg <= 2'h0;
                if (scan_enable) begin
                    scan_pos_reg <= scan_nxt;
                end
                if (event_done) begin
                    smp_cnt_reg  <= 4'h0;
                    half_reg     <= split_mode & ~half_reg;
                    conv_seq_reg <= 7'(conv_seq_reg + 7'h01);
                end else begin
                    smp_cnt_reg <= 4'(smp_cnt_reg + 4'h1);
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            result_reg   <= 16'h0000;
            dma_addr_reg <= 11'h000;
            dma_req_reg  <= 1'b0;
            prdata_o     <= 32'h0000_0000;
        end else begin
            dma_req_reg <= conv_end;
            if (conv_end) begin
                result_reg   <= fmt_word;
                dma_addr_reg <= addr_sel;
            end
            if (rd_setup) begin
                prdata_o <= 32'h0000_0000;
                case (1'b1)
                    hit_main:    prdata_o[15:0] <= {main_reg[15:4], simultaneous_sample,
                                                    main_reg[2:0]};
                    hit_chan:    prdata_o[15:0] <= {chan_reg[15:10], channel_count, chan_reg[7:0]};
                    hit_timing:  prdata_o[15:0] <= timing_reg;
                    hit_dmalen:  prdata_o[2:0]  <= dmalen_reg;
                    hit_result:  prdata_o[15:0] <= result_reg;
                    hit_dmaaddr: prdata_o[10:0] <= dma_addr_reg;
                    hit_scan:    prdata_o       <= scan_reg;
                    hit_stat:    prdata_o[1:0]  <= irq_stat_reg;
                    hit_mask:    prdata_o[1:0]  <= irq_mask_reg;
                    default:     prdata_o       <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign sample_o = (state_reg == ADCSC_ST_SAMPLE) & run;
    assign sample_chan_o = simultaneous_sample
                           ? (channel_count[1] ? 4'hf : {2'h0, |channel_count, 1'b1})
                           : (4'h1 << chan_idx_reg);
    assign ch0_input_o = scan_enable ? scan_pos_reg : 5'h00;
    assign dma_req_o = dma_req_reg;
    assign dma_addr_o = dma_addr_reg;
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    chk_done_on_end: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        conv_end |=> main_reg[`ADCSC_B_DONE])
        else $error("done not set after conversion");
    chk_off_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !module_on |=> state_reg == ADCSC_ST_OFF && !sample_o && !dma_req_o)
        else $error("activity while module off");
    chk_idle_freeze: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        halted && module_on |=> $stable(state_reg))
        else $error("state moved while idle stopped");
    chk_hw_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        start_conv |=> !main_reg[`ADCSC_B_SAMPLE])
        else $error("sample bit not cleared at start");
    chk_done_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        start_conv && !conv_end |=> !main_reg[`ADCSC_B_DONE])
        else $error("done kept at start");
    chk_auto_restart: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        seq_done && auto_sample && run |=> state_reg == ADCSC_ST_SAMPLE)
        else $error("auto sample did not restart");
    chk_div_period: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tad_tick && conversion_clock_divisor == 6'h01 && run
        ##1 run && $stable(timing_reg) && state_next == state_reg
        |-> !tad_tick ##1 (tad_tick || !run || !$stable(timing_reg)))
        else $error("conversion clock period wrong");
    chk_sim_zero12: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        res12 |-> !simultaneous_sample && channel_count == 2'h0)
        else $error("12-bit fields not zero");
    chk_irq_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (|(irq_events & irq_mask_reg)) && !(wr_en && hit_mask) |=> irq_o)
        else $error("irq missing after event");
endmodule

// *** adcsc_far_model.sv ***
// far-side model: analog core result lines and the three trigger sources
`timescale 1ns/100ps
module adcsc_far_model (
    input  wire logic        clk_i,
    input  wire logic        sample_i,
    input  wire logic [11:0] value_i,
    input  wire logic        fire_i,
    input  wire logic [1:0]  sel_i,
    output logic      [11:0] data_o,
    output logic             pwm_o,
    output logic             timer_o,
    output logic             pin_o
);
    // result is not settled while sampling, so show the inverse rather than a stale value
    assign data_o = sample_i ? ~value_i : value_i;
    // one-clock pulses; only the rising edge should count
    always_ff @(posedge clk_i) begin
        pwm_o   <= fire_i && sel_i == 2'd3;
        timer_o <= fire_i && sel_i == 2'd2;
        pin_o   <= fire_i && sel_i == 2'd1;
    end
endmodule

// *** adcsc_core_bench.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "adcsc_regs.svh"
module adcsc_core_bench;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic        dev_idle = 1'b0;
    logic        fire     = 1'b0;
    logic [1:0]  fsel     = 2'h0;
    logic [11:0] paddr    = 12'h000;
    logic [11:0] cval     = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata, rd, w;
    logic [11:0] cdata;
    logic        pready, pslverr, smp, dreq, irq, t_pwm, t_tmr, t_pin, err;
    logic [10:0] da, daddr;
    logic [3:0]  schan;
    logic [4:0]  ch0in;
    int          n_errors = 0;
    int          n_compared = 0;
    int          k, r, f, len;

    always #4 clk = ~clk;

    adcsc_core dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .device_idle_i(dev_idle),
        .trig_pwm_i(t_pwm), .trig_timer_i(t_tmr), .trig_pin_i(t_pin), .sample_o(smp),
        .sample_chan_o(schan), .ch0_input_o(ch0in), .conv_data_i(cdata), .dma_req_o(dreq),
        .dma_addr_o(daddr), .irq_o(irq));

    adcsc_far_model far (.clk_i(clk), .sample_i(smp), .value_i(cval), .fire_i(fire),
        .sel_i(fsel), .data_o(cdata), .pwm_o(t_pwm), .timer_o(t_tmr), .pin_o(t_pin));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // read data and the error flag are taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        err = pslverr;
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_lvl(input logic v);
        for (k = 0; k < 800 && smp !== v; k++) @(posedge clk);
        chk({31'h0, smp}, {31'h0, v});
    endtask

    task automatic wait_dma();
        for (k = 0; k < 3000 && dreq !== 1'b1; k++) @(posedge clk);
        da = daddr;
        chk({31'h0, dreq}, 32'h1);
    endtask

    function automatic logic [15:0] fmt(input logic r12, input logic [1:0] fm,
                                        input logic [11:0] d);
        logic s;
        s = r12 ? ~d[11] : ~d[9];
        case ({r12, fm})
            3'b000: fmt = {6'h0, d[9:0]};
            3'b001: fmt = {{7{s}}, d[8:0]};
            3'b010: fmt = {d[9:0], 6'h0};
            3'b011: fmt = {s, d[8:0], 6'h0};
            3'b100: fmt = {4'h0, d};
            3'b101: fmt = {{5{s}}, d[10:0]};
            3'b110: fmt = {d, 4'h0};
            default: fmt = {s, d[10:0], 4'h0};
        endcase
    endfunction

    task automatic test_done();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (r = 0; r < 4; r++) rdchk(12'(r * 4), 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `ADCSC_OFF_DMALEN, 32'hffff);
        rdchk(`ADCSC_OFF_DMALEN, 32'h7);
        apb(1'b1, `ADCSC_OFF_MAIN, 32'h2);
        repeat (20) begin
            @(posedge clk);
            chk({31'h0, smp}, 32'h0);
        end
        apb(1'b1, `ADCSC_OFF_TIMING, 32'h1);
        for (r = 0; r < 2; r++) begin
            // resolution only changes with the converter off
            apb(1'b1, `ADCSC_OFF_MAIN, r << 10);
            cval <= r ? 12'ha5c : 12'h2a5;
            for (f = 0; f < 4; f++) begin
                w = 32'h8000 | (r << 10) | (f << 8);
                // turn on first: a sample request in the enabling write is not seen
                apb(1'b1, `ADCSC_OFF_MAIN, w);
                apb(1'b1, `ADCSC_OFF_MAIN, w | 32'h2);
                apb(1'b1, `ADCSC_OFF_MAIN, w);
                wait_dma();
                rdchk(`ADCSC_OFF_RESULT, {16'h0, fmt(r[0], f[1:0], cval)});
                rdchk(`ADCSC_OFF_MAIN, w | 32'h1);
            end
            apb(1'b1, `ADCSC_OFF_MAIN, 32'h8 | (r << 10));
            rdchk(`ADCSC_OFF_MAIN, r ? 32'h400 : 32'h8);
            apb(1'b1, `ADCSC_OFF_CHAN, 32'h300);
            rdchk(`ADCSC_OFF_CHAN, r ? 32'h0 : 32'h300);
            apb(1'b1, `ADCSC_OFF_CHAN, 32'h0);
        end
        apb(1'b1, `ADCSC_OFF_MAIN, 32'h0);
        for (r = 1; r < 4; r++) begin
            w = 32'h8004 | (r << 5);
            apb(1'b1, `ADCSC_OFF_MAIN, w);
            for (f = 0; f < 2; f++) begin
                repeat (4) @(posedge clk);
                fsel <= 2'(r);
                fire <= 1'b1;
                @(posedge clk);
                fire <= 1'b0;
                rdchk(`ADCSC_OFF_MAIN, w);
                wait_dma();
                chk({21'h0, da}, 32'((r - 1) * 2 + f));
                rdchk(`ADCSC_OFF_MAIN, w | 32'h3);
            end
        end
        dev_idle <= 1'b1;
        apb(1'b1, `ADCSC_OFF_MAIN, 32'ha004);
        repeat (10) @(posedge clk);
        chk({31'h0, smp}, 32'h0);
        dev_idle <= 1'b0;
        wait_lvl(1'b1);
        chk({28'h0, schan}, 32'h1);
        chk({27'h0, ch0in}, 32'h0);
        apb(1'b1, `ADCSC_OFF_MAIN, 32'h0);
        apb(1'b1, `ADCSC_OFF_TIMING, 32'h301);
        apb(1'b1, `ADCSC_OFF_IRQ_MASK, 32'h2);
        rdchk(`ADCSC_OFF_IRQ_MASK, 32'h2);
        apb(1'b1, `ADCSC_OFF_MAIN, 32'h80e4);
        wait_dma();
        chk({31'h0, irq}, 32'h1);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        // three periods of two clocks each
        for (len = 0; len < 100 && smp === 1'b1; len++) @(posedge clk);
        chk(32'(len), 32'h6);
        apb(1'b1, `ADCSC_OFF_MAIN, 32'h0);
        rdchk(`ADCSC_OFF_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        rdchk(`ADCSC_OFF_IRQ_STAT, 32'h0);
        test_done();
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule
